// ===== rtl/smp_pkg.sv
// constants and command codes for the serial memory programming port
package smp_pkg;
    localparam int CLK_MHZ = 200;
    localparam int BUSY_LOW_MAX_NS = 1000;
    localparam int WRITE_MIN_NS = 3_700_000;
    localparam int WRITE_MAX_NS = 4_500_000;
    localparam int ERASE_MIN_NS = 7_500_000;
    localparam int ERASE_MAX_NS = 9_000_000;
    // least times round up, longest times round down
    localparam int BUSY_LOW_MAX_CYC = (BUSY_LOW_MAX_NS * CLK_MHZ) / 1000;
    localparam int WRITE_CYC = (WRITE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_MAX_CYC = (WRITE_MAX_NS * CLK_MHZ) / 1000;
    localparam int ERASE_CYC = (ERASE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_MAX_CYC = (ERASE_MAX_NS * CLK_MHZ) / 1000;
    localparam int TIMER_W = 22;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h1F;
    localparam logic [BIT_CNT_W-1:0] BYTE2_END = 5'h0F;
    localparam logic [BIT_CNT_W-1:0] BYTE3_END = 5'h17;
    localparam logic [7:0] OP_PROG_EN = 8'hAC;
    localparam logic [7:0] PROG_EN_KEY = 8'h53;
    localparam logic [2:0] ERASE_KEY = 3'h4;
    localparam logic [7:0] OP_LOAD_EXT = 8'h4D;
    localparam logic [7:0] OP_READ_PM = 8'h20;
    localparam logic [7:0] OP_LOAD_PM = 8'h40;
    localparam logic [7:0] HIGH_SEL_MASK = 8'hF7;
    localparam int HIGH_SEL_BIT = 3;
    localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
    localparam logic [7:0] OP_READ_EE = 8'hA0;
    localparam logic [7:0] OP_WRITE_EE = 8'hC0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic PIN_IDLE = 1'b1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } smp_state_e;
endpackage

// ===== rtl/smp_prog_port.sv
// serial programming port: link decoder, memory arrays and busy timer
`timescale 1ns/1ps
module smp_prog_port #(
    parameter int FLASH_AW = 8,
    parameter int PAGE_AW = 4,
    parameter int EE_AW = 8,
    parameter int WRITE_CYCLES = smp_pkg::WRITE_CYC,
    parameter int ERASE_CYCLES = smp_pkg::ERASE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic prog_reset_n,
    input wire logic serial_clk,
    input wire logic serial_prog_in,
    output logic serial_prog_out,
    output logic operation_done_flag
);
    import smp_pkg::*;

    localparam int FLASH_WORDS = 2 ** FLASH_AW;
    localparam int PAGE_WORDS = 2 ** PAGE_AW;
    localparam int EE_BYTES = 2 ** EE_AW;

    // pin synchronisers; stage 0 feeds only stage 1
    logic [1:0] rst_sync_q;
    logic [2:0] sck_sync_q;
    logic [1:0] din_sync_q;
    logic [31:0] shift_q;
    logic [BIT_CNT_W-1:0] bit_q;
    logic [7:0] out_q;
    logic [7:0] resp_q;
    logic load_pend_q;
    logic enabled_q;
    logic [7:0] ext_q;
    smp_state_e state_q;
    logic erase_q;
    logic [TIMER_W-1:0] timer_q;
    logic done_q;
    logic [15:0] flash_mem [FLASH_WORDS];
    logic [15:0] page_buf [PAGE_WORDS];
    logic [7:0] ee_mem [EE_BYTES];

    // edges found on the core clock, so its rate bounds the link rate
    wire session_w = ~rst_sync_q[1];
    wire sck_rise_w = sck_sync_q[1] & ~sck_sync_q[2];
    wire sck_fall_w = ~sck_sync_q[1] & sck_sync_q[2];
    wire take_w = session_w & sck_rise_w;
    wire [31:0] word_w = {shift_q[30:0], din_sync_q[1]};
    wire byte_end_w = take_w & (bit_q[2:0] == 3'h7);
    wire word_end_w = take_w & (bit_q == LAST_BIT);
    wire [7:0] b1_w = word_w[31:24];
    wire [7:0] b2_w = word_w[23:16];
    wire [7:0] b3_w = word_w[15:8];
    wire [7:0] b4_w = word_w[7:0];

    wire prog_en_w = (b1_w == OP_PROG_EN) & (b2_w == PROG_EN_KEY);
    wire accept_w = enabled_q & (state_q == ST_IDLE);
    wire erase_go_w = word_end_w & accept_w & (b1_w == OP_PROG_EN)
        & (b2_w[7:5] == ERASE_KEY);
    wire ext_go_w = word_end_w & enabled_q & (b1_w == OP_LOAD_EXT);
    wire load_go_w = word_end_w & enabled_q & ((b1_w & HIGH_SEL_MASK) == OP_LOAD_PM);
    wire page_go_w = word_end_w & accept_w & (b1_w == OP_WRITE_PAGE);
    wire ee_go_w = word_end_w & accept_w & (b1_w == OP_WRITE_EE);
    wire write_go_w = page_go_w | ee_go_w;
    wire start_w = write_go_w | erase_go_w;

    // read addresses come from bytes two and three as byte three ends
    wire [23:0] fl_full_w = {ext_q, word_w[15:0]};
    wire [FLASH_AW-1:0] rd_fl_addr_w = fl_full_w[FLASH_AW-1:0];
    wire [11:0] ee_full_w = {word_w[11:8], word_w[7:0]};
    wire [EE_AW-1:0] rd_ee_addr_w = ee_full_w[EE_AW-1:0];
    wire [7:0] r1_w = word_w[23:16];
    wire [15:0] rd_word_w = flash_mem[rd_fl_addr_w];
    wire [7:0] rd_fl_byte_w = r1_w[HIGH_SEL_BIT] ? rd_word_w[15:8] : rd_word_w[7:0];
    wire rd_pm_w = (r1_w & HIGH_SEL_MASK) == OP_READ_PM;
    wire rd_ee_w = r1_w == OP_READ_EE;
    wire [7:0] read_byte_w = rd_pm_w ? rd_fl_byte_w :
        (rd_ee_w ? ee_mem[rd_ee_addr_w] : word_w[7:0]);
    // the byte just finished is echoed by default, so 0x53 returns in byte three
    wire [7:0] resp_d = (bit_q == BYTE3_END) ? read_byte_w : word_w[7:0];

    wire [23:0] wr_full_w = {ext_q, b2_w, b3_w};
    wire [FLASH_AW-1:0] wr_fl_addr_w = wr_full_w[FLASH_AW-1:0];
    wire [FLASH_AW-PAGE_AW-1:0] page_sel_w = wr_fl_addr_w[FLASH_AW-1:PAGE_AW];
    wire [PAGE_AW-1:0] page_idx_w = b3_w[PAGE_AW-1:0];
    wire [11:0] ee_wr_full_w = {b2_w[3:0], b3_w};
    wire [EE_AW-1:0] wr_ee_addr_w = ee_wr_full_w[EE_AW-1:0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_sync_q <= {PIN_IDLE, PIN_IDLE};
            sck_sync_q <= 3'h0;
            din_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], prog_reset_n};
            sck_sync_q <= {sck_sync_q[1:0], serial_clk};
            din_sync_q <= {din_sync_q[0], serial_prog_in};
        end
    end

    // link shifter; taking reset high drops the session and its enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_q <= 32'h0000_0000;
            bit_q <= 5'h00;
            enabled_q <= 1'b0;
            ext_q <= ZERO_BYTE;
        end else if (!session_w) begin
            bit_q <= 5'h00;
            enabled_q <= 1'b0;
        end else if (take_w) begin
            shift_q <= word_w;
            bit_q <= bit_q + 5'h01;
            if (word_end_w && prog_en_w) begin
                enabled_q <= 1'b1;
            end
            if (ext_go_w) begin
                ext_q <= b3_w;
            end
        end
    end

    // output byte loads on the falling edge after a byte ends
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_q <= ZERO_BYTE;
            resp_q <= ZERO_BYTE;
            load_pend_q <= 1'b0;
        end else if (!session_w) begin
            out_q <= ZERO_BYTE;
            load_pend_q <= 1'b0;
        end else if (byte_end_w) begin
            resp_q <= (bit_q == BYTE2_END || bit_q == BYTE3_END) ? resp_d : ZERO_BYTE;
            load_pend_q <= 1'b1;
        end else if (sck_fall_w) begin
            out_q <= load_pend_q ? resp_q : {out_q[6:0], 1'b0};
            load_pend_q <= 1'b0;
        end
    end

    // arrays carry no reset; their content is what was programmed
    always_ff @(posedge clk) begin
        if (erase_go_w) begin
            for (int i = 0; i < FLASH_WORDS; i++) begin
                flash_mem[i] <= {ERASED_BYTE, ERASED_BYTE};
            end
            for (int i = 0; i < EE_BYTES; i++) begin
                ee_mem[i] <= ERASED_BYTE;
            end
        end else begin
            if (ee_go_w) begin
                ee_mem[wr_ee_addr_w] <= b4_w;
            end
            if (page_go_w) begin
                for (int j = 0; j < PAGE_WORDS; j++) begin
                    flash_mem[{page_sel_w, PAGE_AW'(j)}] <= page_buf[j];
                end
            end
        end
        if (load_go_w) begin
            if (b1_w[HIGH_SEL_BIT]) begin
                page_buf[page_idx_w][15:8] <= b4_w;
            end else begin
                page_buf[page_idx_w][7:0] <= b4_w;
            end
        end
    end

    // self-timed busy interval; flag low from the cycle after the start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            erase_q <= 1'b0;
            timer_q <= 22'h00_0000;
            done_q <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_w) begin
                        state_q <= ST_BUSY;
                        erase_q <= erase_go_w;
                        timer_q <= erase_go_w ? TIMER_W'(ERASE_CYCLES - 1)
                            : TIMER_W'(WRITE_CYCLES - 1);
                        done_q <= 1'b0;
                    end
                end
                ST_BUSY: begin
                    if (timer_q == 22'h00_0000) begin
                        state_q <= ST_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        timer_q <= timer_q - 22'h00_0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    done_q <= 1'b1;
                end
            endcase
        end
    end

    assign serial_prog_out = out_q[7];
    assign operation_done_flag = done_q;

    // busy length helper for the timing checks
    logic [TIMER_W-1:0] busy_len_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_len_q <= 22'h00_0000;
        end else begin
            busy_len_q <= done_q ? 22'h00_0000 : busy_len_q + 22'h00_0001;
        end
    end

    busy_drop_a: assert property (@(posedge clk) disable iff (reset)
        start_w |=> !operation_done_flag)
        else $error("ready flag did not drop after start");
    write_len_a: assert property (@(posedge clk) disable iff (reset)
        $rose(done_q) && !erase_q |-> busy_len_q == TIMER_W'(WRITE_CYCLES))
        else $error("write busy length wrong");
    erase_len_a: assert property (@(posedge clk) disable iff (reset)
        $rose(done_q) && erase_q |-> busy_len_q == TIMER_W'(ERASE_CYCLES))
        else $error("erase busy length wrong");
    refuse_off_a: assert property (@(posedge clk) disable iff (reset)
        !enabled_q |-> !start_w && !load_go_w)
        else $error("operation started without enable");
    busy_ignore_a: assert property (@(posedge clk) disable iff (reset)
        !operation_done_flag |-> !start_w)
        else $error("operation started while busy");
    session_end_a: assert property (@(posedge clk) disable iff (reset)
        !session_w |=> !enabled_q && bit_q == 5'h00)
        else $error("session state kept with reset pin high");
    enable_key_a: assert property (@(posedge clk) disable iff (reset)
        $rose(enabled_q) |-> $past(word_end_w)
        && $past(shift_q[30:15]) == {OP_PROG_EN, PROG_EN_KEY})
        else $error("enable without correct key bytes");
    erase_fill_a: assert property (@(posedge clk) disable iff (reset)
        erase_go_w |=> flash_mem[0] == 16'hFFFF && ee_mem[0] == ERASED_BYTE)
        else $error("chip erase left data");
    echo_key_a: assert property (@(posedge clk) disable iff (reset)
        byte_end_w && bit_q == BYTE2_END |=> resp_q == $past(word_w[7:0]))
        else $error("second byte not echoed");
    sample_rise_a: assert property (@(posedge clk) disable iff (reset)
        session_w && !sck_rise_w |=> bit_q == $past(bit_q))
        else $error("bit taken without rising edge");
    shift_fall_a: assert property (@(posedge clk) disable iff (reset)
        session_w && !sck_fall_w |=> out_q == $past(out_q))
        else $error("output moved without falling edge");
    ee_write_a: assert property (@(posedge clk) disable iff (reset)
        ee_go_w |=> ee_mem[$past(wr_ee_addr_w)] == $past(b4_w))
        else $error("eeprom byte not replaced");
endmodule

// ===== test/smp_programmer.sv
// programmer model that drives the serial programming link
`timescale 1ns/1ps
module smp_programmer #(
    parameter int HALF_NS = 24
) (
    output logic serial_clk,
    output logic serial_prog_in,
    input wire logic serial_prog_out
);
    // serial clock rests low between frames
    initial begin
        serial_clk = 1'b0;
        serial_prog_in = 1'b0;
    end
    // one instruction msb first; all 32 bits go out even on a bad echo
    task automatic send_word(input logic [31:0] cmd, output logic [31:0] resp);
        for (int i = 31; i >= 0; i--) begin
            serial_prog_in = cmd[i];
            #HALF_NS;
            serial_clk = 1'b1;
            resp[i] = serial_prog_out;
            #HALF_NS;
            serial_clk = 1'b0;
        end
        // idle line flips so a stale bit cannot pass for a real one
        serial_prog_in = ~cmd[0];
    endtask
endmodule

// ===== test/tb_smp_prog_port.sv
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module tb_smp_prog_port;
    import smp_pkg::*;
    // short busy counts keep the run small
    localparam int WR_CYC = 400;
    localparam int ER_CYC = 800;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic prog_reset_n = 1'b1;
    logic serial_clk;
    logic serial_prog_in;
    logic serial_prog_out;
    logic operation_done_flag;
    logic [31:0] resp;
    int mismatches = 0;
    int num_checks = 0;
    int low_run = 0;
    int last_run = 0;
    always #2.5 clk = ~clk;
    smp_prog_port #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) DUT (
        .clk(clk), .reset(reset), .prog_reset_n(prog_reset_n), .serial_clk(serial_clk),
        .serial_prog_in(serial_prog_in), .serial_prog_out(serial_prog_out),
        .operation_done_flag(operation_done_flag));
    smp_programmer prog (.serial_clk(serial_clk), .serial_prog_in(serial_prog_in),
        .serial_prog_out(serial_prog_out));
    // length of the latest busy stretch in core cycles
    always @(posedge clk) begin
        if (operation_done_flag === 1'b0) begin
            low_run <= low_run + 1;
        end else if (low_run != 0) begin
            last_run <= low_run;
            low_run <= 0;
        end
    end
    task automatic fail(input string msg);
        mismatches++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("byte %h want %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) fail($sformatf("flag %b want %b", got, exp));
    endtask
    task automatic chk_int(input int got, input int exp);
        num_checks++;
        if (got != exp) fail($sformatf("busy %0d want %0d", got, exp));
    endtask
    task automatic xfer(input logic [31:0] cmd);
        prog.send_word(cmd, resp);
    endtask
    task automatic session(input logic on);
        @(negedge clk);
        prog_reset_n = ~on;
        repeat (6) @(negedge clk);
    endtask
    task automatic wait_ready(input int limit);
        int n;
        n = 0;
        while (operation_done_flag !== 1'b1 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (n >= limit) fail("busy never ended");
    endtask
    // busy must show within a few cycles, far inside one microsecond
    task automatic timed_op(input logic [31:0] cmd, input int exp_cyc);
        xfer(cmd);
        repeat (4) @(negedge clk);
        chk_bit(operation_done_flag, 1'b0);
        wait_ready(exp_cyc + 50);
        @(negedge clk);
        chk_int(last_run, exp_cyc);
    endtask
    task automatic t_locked();
        session(1'b1);
        xfer(32'hAC80_0000);
        repeat (50) @(negedge clk);
        chk_bit(operation_done_flag, 1'b1);
        $display("done locked");
    endtask
    task automatic t_enable();
        xfer({OP_PROG_EN, PROG_EN_KEY, 16'h0000});
        chk8(resp[23:16], ZERO_BYTE);
        chk8(resp[15:8], PROG_EN_KEY);
        $display("done enable");
    endtask
    task automatic t_erase();
        timed_op(32'hAC80_0000, ER_CYC);
        xfer(32'hA000_0500);
        chk8(resp[7:0], ERASED_BYTE);
        xfer(32'h2000_0300);
        chk8(resp[7:0], ERASED_BYTE);
        $display("done erase");
    endtask
    // second write replaces the whole byte, so bits the first left at zero return to one
    task automatic t_ee_write();
        timed_op(32'hC000_053C, WR_CYC);
        timed_op(32'hC000_05C3, WR_CYC);
        xfer(32'hA000_0500);
        chk8(resp[7:0], 8'hC3);
        $display("done eeprom");
    endtask
    // extended address and high byte paths are exercised too
    task automatic t_flash();
        xfer(32'h4D00_0000);
        xfer(32'h4000_03A5);
        xfer(32'h4800_035A);
        timed_op(32'h4C00_0000, WR_CYC);
        xfer(32'h2000_0300);
        chk8(resp[7:0], 8'hA5);
        xfer(32'h2800_0300);
        chk8(resp[7:0], 8'h5A);
        $display("done flash");
    endtask
    task automatic t_busy_ignore();
        xfer(32'hC000_0611);
        xfer(32'hC000_0622);
        wait_ready(WR_CYC + 50);
        repeat (WR_CYC / 2) @(negedge clk);
        chk_bit(operation_done_flag, 1'b1);
        chk_int(last_run, WR_CYC);
        xfer(32'hA000_0600);
        chk8(resp[7:0], 8'h11);
        $display("done busy ignore");
    endtask
    task automatic t_session_end();
        session(1'b0);
        xfer({OP_PROG_EN, PROG_EN_KEY, 16'h0000});
        chk8(resp[15:8], ZERO_BYTE);
        session(1'b1);
        xfer(32'hAC80_0000);
        repeat (50) @(negedge clk);
        chk_bit(operation_done_flag, 1'b1);
        $display("done session end");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        fail("watchdog expired");
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        t_locked();
        t_enable();
        t_erase();
        t_ee_write();
        t_flash();
        t_busy_ignore();
        t_session_end();
        wrap_up();
    end
endmodule
